// [efs_defines.svh]
// Behaviour
// - pulse count, direction level sets sign
// - quadrature decode, A leading B forward
// - quadrature setting resets to enabled
// - invert setting flips sign in both modes
// - modes 3/4 single train: analogue sign unless lock bit set, then direction level
// - encoder rpm from line count
// - motor speed equals encoder speed times ratio
// - motor speed percent times 100 of max rpm
// - speed outputs independent, zero without pulses
// - subtract current-proportional drop from armature voltage with source EFS_SRC_AV or field weakening
// - comp percent from amps, ohms, volts
// - field feedback trim factor at least one
// - armature voltage trim factor at least one
// - tacho trim 1.0000 to 1.1000
// - field weakening clamps armature voltage at rated
// - feedback source select codes 0 to 4
`ifndef EFS_DEFINES_SVH
`define EFS_DEFINES_SVH
`define EFS_REG_CTRL        12'h000
`define EFS_REG_LINES       12'h004
`define EFS_REG_RATIO       12'h008
`define EFS_REG_MAXRPM      12'h00C
`define EFS_REG_IRCOMP      12'h010
`define EFS_REG_FLDTRIM     12'h014
`define EFS_REG_AVTRIM      12'h018
`define EFS_REG_TACHTRIM    12'h01C
`define EFS_REG_ENCRPM      12'h020
`define EFS_REG_MOTPCT      12'h024
`define EFS_REG_AVOUT       12'h028
`define EFS_REG_TACHOUT     12'h02C
`define EFS_REG_FLDOUT      12'h030
`define EFS_REG_COUNT       12'h034
`define EFS_BIT_QUAD        0
`define EFS_BIT_INV         1
`define EFS_BIT_LOCK        2
`define EFS_BIT_FWEAK       3
`define EFS_FLD_SRC_LO      4
`define EFS_CTRL_RST        32'h0000_0001
`define EFS_LINES_RST       16'h0400
`define EFS_RATIO_RST       16'h1000
`define EFS_MAXRPM_RST      16'h07D0
`define EFS_TRIM_ONE        16'h2710
`define EFS_TACH_MAX        16'h2AF8
`define EFS_CLK_HZ          100000000
`define EFS_GATE_MS         100
`define EFS_GATE_CYC        (`EFS_CLK_HZ / 1000 * `EFS_GATE_MS)
`define EFS_GATE_PER_MIN    600
`endif

// [efs_pkg.sv]
`default_nettype none
package efs_pkg;
  typedef enum logic [2:0] {
    EFS_SRC_AV, EFS_SRC_TACHO, EFS_SRC_ENC, EFS_SRC_ENC_AV, EFS_SRC_ENC_TACHO
  } efs_src_e;
  typedef struct packed {
    logic signed [15:0] armature_voltage_feedback;
    logic signed [15:0] tacho;
    logic        [15:0] field_current;
    logic signed [15:0] armature_current;
  } efs_analog_s;
  typedef struct packed {
    logic signed [15:0] av;
    logic signed [15:0] tacho;
    logic        [15:0] field;
  } efs_scaled_s;
endpackage
`default_nettype wire

// [efs_encoder_feedback_scaling.sv]
// The placing of the registers and the APB register port are this design's own decisions.
`include "efs_defines.svh"
`default_nettype none
module efs_encoder_feedback_scaling
  import efs_pkg::*;
#(
  parameter int unsigned GATE_CYC = `EFS_GATE_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pulse_train_a_input,
  input  wire logic        direction_or_train_b_input,
  input  wire efs_analog_s analog_in,
  output efs_scaled_s      scaled_out,
  output logic             encoder_sign_reverse
);
  logic        [31:0] ctrl_reg, ctrl_next;
  logic        [15:0] lines_reg, lines_next;
  logic        [15:0] ratio_reg, ratio_next;
  logic        [15:0] maxrpm_reg, maxrpm_next;
  logic        [15:0] ircomp_reg, ircomp_next;
  logic        [15:0] fldtrim_reg, fldtrim_next;
  logic        [15:0] avtrim_reg, avtrim_next;
  logic        [15:0] tachtrim_reg, tachtrim_next;
  logic        [31:0] prdata_reg, prdata_next;
  logic               pready_reg, pready_next;
  logic               pslverr_reg, pslverr_next;
  logic        [2:0]  a_sync_reg;
  logic        [2:0]  b_sync_reg;
  logic        [1:0]  ab_prev_reg, ab_prev_next;
  logic signed [31:0] cnt_reg, cnt_next;
  logic signed [31:0] snap_reg, snap_next;
  logic        [31:0] gate_reg, gate_next;
  logic signed [31:0] rpm_reg, rpm_next;
  logic signed [31:0] pct_reg, pct_next;
  efs_scaled_s        scaled_reg, scaled_next;
  logic               sign_reg, sign_next;

  logic               wr;
  logic               rd;
  logic               a_now;
  logic               b_now;
  logic               rise_a;
  logic               quad;
  logic               inv;
  logic               lock;
  logic               fweak;
  logic        [1:0]  ab_now;
  logic        [2:0]  src;
  logic               analog_neg;
  logic               single_sign_rev;
  logic               dir_level_rev;
  logic signed [1:0]  step;

  assign wr    = psel && penable && pwrite && !pready_reg;
  assign rd    = psel && penable && !pwrite && !pready_reg;
  assign quad  = ctrl_reg[`EFS_BIT_QUAD];
  assign inv   = ctrl_reg[`EFS_BIT_INV];
  assign lock  = ctrl_reg[`EFS_BIT_LOCK];
  assign fweak = ctrl_reg[`EFS_BIT_FWEAK];
  assign src   = ctrl_reg[`EFS_FLD_SRC_LO +: 3];

  // apb register file, one wait state
  always_comb begin
    ctrl_next = ctrl_reg;
    lines_next = lines_reg;
    ratio_next = ratio_reg;
    maxrpm_next = maxrpm_reg;
    ircomp_next = ircomp_reg;
    fldtrim_next = fldtrim_reg;
    avtrim_next = avtrim_reg;
    tachtrim_next = tachtrim_reg;
    prdata_next = prdata_reg;
    pready_next = psel && penable && !pready_reg;
    pslverr_next = 1'b0;
    if (wr) begin
      case (paddr)
        `EFS_REG_CTRL:   ctrl_next = {25'h0000000, pwdata[6:0]};
        `EFS_REG_LINES:  lines_next = pwdata[15:0];
        `EFS_REG_RATIO:  ratio_next = pwdata[15:0];
        `EFS_REG_MAXRPM: maxrpm_next = pwdata[15:0];
        `EFS_REG_IRCOMP: ircomp_next = pwdata[15:0];
        `EFS_REG_FLDTRIM: fldtrim_next = (pwdata[15:0] < `EFS_TRIM_ONE) ?
                                         `EFS_TRIM_ONE : pwdata[15:0];
        `EFS_REG_AVTRIM: avtrim_next = (pwdata[15:0] < `EFS_TRIM_ONE) ?
                                       `EFS_TRIM_ONE : pwdata[15:0];
        `EFS_REG_TACHTRIM: tachtrim_next = (pwdata[15:0] < `EFS_TRIM_ONE) ? `EFS_TRIM_ONE :
                                           (pwdata[15:0] > `EFS_TACH_MAX) ? `EFS_TACH_MAX :
                                           pwdata[15:0];
        `EFS_REG_ENCRPM, `EFS_REG_MOTPCT, `EFS_REG_AVOUT, `EFS_REG_TACHOUT,
        `EFS_REG_FLDOUT, `EFS_REG_COUNT: pslverr_next = 1'b1;
        default: pslverr_next = 1'b1;
      endcase
    end
    if (rd) begin
      case (paddr)
        `EFS_REG_CTRL:     prdata_next = ctrl_reg;
        `EFS_REG_LINES:    prdata_next = {16'h0000, lines_reg};
        `EFS_REG_RATIO:    prdata_next = {16'h0000, ratio_reg};
        `EFS_REG_MAXRPM:   prdata_next = {16'h0000, maxrpm_reg};
        `EFS_REG_IRCOMP:   prdata_next = {16'h0000, ircomp_reg};
        `EFS_REG_FLDTRIM:  prdata_next = {16'h0000, fldtrim_reg};
        `EFS_REG_AVTRIM:   prdata_next = {16'h0000, avtrim_reg};
        `EFS_REG_TACHTRIM: prdata_next = {16'h0000, tachtrim_reg};
        `EFS_REG_ENCRPM:   prdata_next = rpm_reg;
        `EFS_REG_MOTPCT:   prdata_next = pct_reg;
        `EFS_REG_AVOUT:    prdata_next = {{16{scaled_reg.av[15]}}, scaled_reg.av};
        `EFS_REG_TACHOUT:  prdata_next = {{16{scaled_reg.tacho[15]}}, scaled_reg.tacho};
        `EFS_REG_FLDOUT:   prdata_next = {16'h0000, scaled_reg.field};
        `EFS_REG_COUNT:    prdata_next = cnt_reg;
        default: begin
          prdata_next = 32'h0000_0000;
          pslverr_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `EFS_CTRL_RST;
      lines_reg <= `EFS_LINES_RST;
      ratio_reg <= `EFS_RATIO_RST;
      maxrpm_reg <= `EFS_MAXRPM_RST;
      ircomp_reg <= 16'h0000;
      fldtrim_reg <= `EFS_TRIM_ONE;
      avtrim_reg <= `EFS_TRIM_ONE;
      tachtrim_reg <= `EFS_TRIM_ONE;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      lines_reg <= lines_next;
      ratio_reg <= ratio_next;
      maxrpm_reg <= maxrpm_next;
      ircomp_reg <= ircomp_next;
      fldtrim_reg <= fldtrim_next;
      avtrim_reg <= avtrim_next;
      tachtrim_reg <= tachtrim_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // raw pins: second stage keeps metastability away from the decoder
  // three-stage input sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_sync_reg <= 3'h0;
      b_sync_reg <= 3'h0;
    end else begin
      a_sync_reg <= {a_sync_reg[1:0], pulse_train_a_input};
      b_sync_reg <= {b_sync_reg[1:0], direction_or_train_b_input};
    end
  end

  // a level counts only once stages two and three agree
  assign a_now  = (a_sync_reg[2] == a_sync_reg[1]) ? a_sync_reg[1] : ab_prev_reg[1];
  assign b_now  = (b_sync_reg[2] == b_sync_reg[1]) ? b_sync_reg[1] : ab_prev_reg[0];
  assign ab_now = {a_now, b_now};
  assign rise_a = a_now && !ab_prev_reg[1];
  assign analog_neg = (src == 3'(EFS_SRC_ENC_AV)) ? analog_in.armature_voltage_feedback[15] :
                      analog_in.tacho[15];
  assign dir_level_rev = !b_now;
  assign single_sign_rev = ((src == 3'(EFS_SRC_ENC_AV) || src == 3'(EFS_SRC_ENC_TACHO))
                            && !lock) ? analog_neg : dir_level_rev;

  always_comb begin
    step = 2'sd0;
    if (quad) begin
      case ({ab_prev_reg, ab_now})
        4'b00_10, 4'b10_11, 4'b11_01, 4'b01_00: step = 2'sd1;
        4'b00_01, 4'b01_11, 4'b11_10, 4'b10_00: step = -2'sd1;
        default: step = 2'sd0;
      endcase
    end else if (rise_a) begin
      step = single_sign_rev ? -2'sd1 : 2'sd1;
    end
    if (inv) begin
      step = -step;
    end
  end

  // gate window: long window trades update rate for resolution
  always_comb begin
    ab_prev_next = ab_now;
    gate_next = gate_reg + 32'd1;
    cnt_next = cnt_reg + 32'(step);
    snap_next = snap_reg;
    sign_next = sign_reg;
    if (step != 2'sd0) begin
      sign_next = (step < 2'sd0);
    end
    // snapshot on wrap so the speed registers always reflect a whole window
    if (gate_reg >= GATE_CYC - 1) begin
      gate_next = 32'd0;
      cnt_next = 32'(step);
      snap_next = cnt_reg;
    end
  end

  always_comb begin
    logic signed [47:0] r;
    logic signed [63:0] m;
    m = '0;
    r = 48'(snap_reg) * 48'(`EFS_GATE_PER_MIN);
    if (quad) begin
      r = r >>> 2;
    end
    rpm_next = (lines_reg == 16'h0000) ? 32'sd0 : 32'(r / $signed({32'h0, lines_reg}));
    m = (64'(rpm_reg) * $signed({48'h0, ratio_reg})) >>> 12;
    // percent times 100 of max rpm
    pct_next = (maxrpm_reg == 16'h0000) ? 32'sd0 :
               32'((m * 64'sd10000) / $signed({48'h0, maxrpm_reg}));
  end

  // analogue path: compensation, clamp and trims
  always_comb begin
    logic signed [47:0] drop, av, t, f;
    t = '0;
    f = '0;
    drop = (48'(analog_in.armature_current) * $signed({32'h0, ircomp_reg})) / 48'sd10000;
    av = 48'(analog_in.armature_voltage_feedback);
    if (src == 3'(EFS_SRC_AV) || fweak) begin
      av = av - drop;
    end
    av = (av * $signed({32'h0, avtrim_reg})) / 48'sd10000;
    if (fweak && av > 48'sd32767) begin
      av = 48'sd32767;
    end
    if (av > 48'sd32767) av = 48'sd32767;
    if (av < -48'sd32768) av = -48'sd32768;
    t = (48'(analog_in.tacho) * $signed({32'h0, tachtrim_reg})) / 48'sd10000;
    if (t > 48'sd32767) t = 48'sd32767;
    if (t < -48'sd32768) t = -48'sd32768;
    f = ($signed({32'h0, analog_in.field_current}) * $signed({32'h0, fldtrim_reg})) / 48'sd10000;
    if (f > 48'sd65535) f = 48'sd65535;
    scaled_next.av = av[15:0];
    scaled_next.tacho = t[15:0];
    scaled_next.field = f[15:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ab_prev_reg <= 2'b00;
      gate_reg <= 32'd0;
      cnt_reg <= 32'sd0;
      snap_reg <= 32'sd0;
      rpm_reg <= 32'sd0;
      pct_reg <= 32'sd0;
      scaled_reg <= '0;
      sign_reg <= 1'b0;
    end else begin
      ab_prev_reg <= ab_prev_next;
      gate_reg <= gate_next;
      cnt_reg <= cnt_next;
      snap_reg <= snap_next;
      rpm_reg <= rpm_next;
      pct_reg <= pct_next;
      scaled_reg <= scaled_next;
      sign_reg <= sign_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign scaled_out = scaled_reg;
  assign encoder_sign_reverse = sign_reg;
endmodule
`default_nettype wire

// [efs_encoder_feedback_scaling_sva.sv]
`default_nettype none
module efs_chk
  import efs_pkg::*;
#(
  parameter int unsigned GATE_CYC = 1000
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pulse_train_a_input,
  input wire logic        direction_or_train_b_input,
  input wire efs_analog_s analog_in,
  input wire efs_scaled_s scaled_out,
  input wire logic        encoder_sign_reverse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  pins_reg;
  efs_analog_s ana_reg;
  logic [3:0]  quiet_reg;
  logic [3:0]  quiet_next;
  // bus traffic or analogue moves may legally retarget the sign, so they restart the count
  always_comb begin
    quiet_next = quiet_reg;
    if (psel || pins_reg != {pulse_train_a_input, direction_or_train_b_input} ||
        ana_reg != analog_in) quiet_next = 4'h0;
    else if (quiet_reg != 4'hF) quiet_next = quiet_reg + 4'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_reg  <= 2'h0;
      ana_reg   <= '0;
      quiet_reg <= 4'h0;
    end else begin
      pins_reg  <= {pulse_train_a_input, direction_or_train_b_input};
      ana_reg   <= analog_in;
      quiet_reg <= quiet_next;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after access");
  idle_quiet_a: assert property (!(psel && penable) |=> !pready)
    else $error("pready without access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  field_trim_a: assert property ($past(presetn) |->
    scaled_out.field >= $past(analog_in.field_current)) else $error("field trim below one");
  tacho_trim_a: assert property ($past(presetn) && $past(analog_in.tacho) > 0 |->
    scaled_out.tacho >= $past(analog_in.tacho) &&
    32'(scaled_out.tacho) * 10 <= 32'($past(analog_in.tacho)) * 11 + 5)
    else $error("tacho trim out of range");
  sign_hold_a: assert property (quiet_reg > 4'h8 |-> $stable(encoder_sign_reverse))
    else $error("sign moved with quiet pins");
  cover property (pready && pslverr);
  cover property (pready && !pwrite);
  cover property ($rose(encoder_sign_reverse));
endmodule
bind efs_encoder_feedback_scaling efs_chk #(.GATE_CYC(GATE_CYC)) efs_chk_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .pulse_train_a_input, .direction_or_train_b_input, .analog_in, .scaled_out,
  .encoder_sign_reverse);
`default_nettype wire

// [efs_enc_model.sv]
`default_nettype none
module efs_enc_model #(
  parameter int PER = 250
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  input  wire logic fwd,
  input  wire logic quad,
  input  wire logic skip,
  output logic      a,
  output logic      b
);
  timeunit 1ns;
  timeprecision 1ps;
  int         cnt;
  int         lim;
  logic [1:0] ph;
  logic [1:0] nph;
  assign nph = ph + (skip ? 2'h2 : (fwd ? 2'h1 : 2'h3));
  // single train toggles at half the rate so a full period stays at 100 kHz
  assign lim = quad ? PER - 1 : 2 * PER - 1;
  // quad edge per PER, single toggle per 2*PER cycles
  // train a on pulse pin, a leads b forward
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      ph  <= 2'h0;
      a   <= 1'b0;
      b   <= 1'b0;
    end else if (run) begin
      cnt <= (cnt >= lim) ? 0 : cnt + 1;
      if (cnt >= lim) begin
        ph <= nph;
        a  <= quad ? nph[0] ^ nph[1] : ~a;
        b  <= quad ? nph[1] : fwd;
      end
    end
  end
endmodule
`default_nettype wire

// [efs_encoder_feedback_scaling_tb_top.sv]
`include "efs_defines.svh"
`default_nettype none
module efs_encoder_feedback_scaling_tb_top import efs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int G = 5000;
  localparam int W = 2 * G + 300;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rev;
  logic        run, fwd, quad, skip, a, b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  efs_analog_s ain;
  efs_scaled_s sout;
  logic [33:0] q[$];
  logic [33:0] e;
  int          mismatches, n_compared, t;
  int          cyc = 0;
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  efs_encoder_feedback_scaling #(.GATE_CYC(G)) efs_encoder_feedback_scaling_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulse_train_a_input(a), .direction_or_train_b_input(b), .analog_in(ain),
    .scaled_out(sout), .encoder_sign_reverse(rev));
  efs_enc_model #(.PER(250)) efs_enc_model_i (.pclk(pclk), .presetn(presetn), .run(run),
    .fwd(fwd), .quad(quad), .skip(skip), .a(a), .b(b));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bus is held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
                     input logic er);
    q.push_back({w, er, d});
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic er = 1'b0);
    apb(1'b1, ad, d, er);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] d, input logic er = 1'b0);
    apb(1'b0, ad, d, er);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = q.pop_front();
      check("apb_err", pslverr, e[32]);
      if (!e[33]) check("apb_rdata", prdata, e[31:0]);
    end
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, run, skip} = 6'h0;
    {fwd, quad, paddr, pwdata, ain} = '0;
    fwd = 1'b1;
    quad = 1'b1;
    rnd = 32'hB56D83F9;
    mismatches = 0;
    n_compared = 0;
    wt(8);
    presetn <= 1'b1;
    rd(`EFS_REG_CTRL, 32'h1);
    rd(`EFS_REG_LINES, 32'h400);
    rd(`EFS_REG_TACHTRIM, 32'h2710);
    rd(`EFS_REG_ENCRPM, 32'h0);
    rd(12'h040, 32'h0, 1'b1);
    wr(`EFS_REG_ENCRPM, 32'h5, 1'b1);
    rd(`EFS_REG_ENCRPM, 32'h0);
    wr(`EFS_REG_TACHTRIM, 32'h3000);
    rd(`EFS_REG_TACHTRIM, 32'h2AF8);
    wr(`EFS_REG_FLDTRIM, 32'h100);
    rd(`EFS_REG_FLDTRIM, 32'h2710);
    wr(`EFS_REG_AVTRIM, 32'h2EE0);
    $display("registers done");
    wr(`EFS_REG_CTRL, 32'h11);
    repeat (3) begin
      rnd = lfsr(rnd);
      t = (rnd[15:0] % 2000) * 10;
      ain <= {16'(t), 16'(t), 1'b0, rnd[31:17], rnd[15:0]};
      wt(3);
      rd(`EFS_REG_AVOUT, 32'(t * 12 / 10));
      rd(`EFS_REG_TACHOUT, 32'(t * 11 / 10));
      rd(`EFS_REG_FLDOUT, {17'h0, rnd[31:17]});
    end
    wr(`EFS_REG_IRCOMP, 32'd500);
    ain <= {16'h2710, 16'h0000, 16'h0000, 16'h07D0};
    // drop 2000 * 5.00% = 100, then trim 1.2: (10000 - 100) * 1.2
    for (int c = 0; c < 2; c++) begin
      wr(`EFS_REG_CTRL, c ? 32'h19 : 32'h01);
      wt(3);
      rd(`EFS_REG_AVOUT, 32'd11880);
    end
    ain <= {16'h7530, 16'h0000, 16'h0000, 16'h07D0};
    wt(3);
    rd(`EFS_REG_AVOUT, 32'd32767);
    $display("trims done");
    wr(`EFS_REG_LINES, 32'd30);
    wr(`EFS_REG_CTRL, 32'h21);
    run <= 1'b1;
    wt(W);
    rd(`EFS_REG_ENCRPM, 32'd100);
    rd(`EFS_REG_MOTPCT, 32'd500);
    wr(`EFS_REG_RATIO, 32'h2000);
    wt(W);
    rd(`EFS_REG_MOTPCT, 32'd1000);
    check("sign_fwd", rev, 32'h0);
    fwd <= 1'b0;
    wt(1000);
    check("sign_rev", rev, 32'h1);
    wr(`EFS_REG_CTRL, 32'h23);
    wt(1000);
    check("sign_inv", rev, 32'h0);
    $display("quadrature done");
    quad <= 1'b0;
    fwd <= 1'b1;
    wr(`EFS_REG_CTRL, 32'h20);
    wt(W);
    // one rising edge per 1000 cycles: 5 per window, 5 * 600 / 30
    rd(`EFS_REG_ENCRPM, 32'd100);
    check("single_fwd", rev, 32'h0);
    fwd <= 1'b0;
    wt(1100);
    check("single_rev", rev, 32'h1);
    fwd <= 1'b1;
    ain <= {-16'sd500, -16'sd500, 32'h0};
    for (int s = 3; s < 5; s++) begin
      wr(`EFS_REG_CTRL, 32'(s << 4));
      wt(1100);
      check("analog_sign", rev, 32'h1);
    end
    wr(`EFS_REG_CTRL, 32'h34);
    wt(1100);
    check("lock_dir", rev, 32'h0);
    $display("single train done");
    quad <= 1'b1;
    skip <= 1'b1;
    wr(`EFS_REG_CTRL, 32'h21);
    wt(W);
    rd(`EFS_REG_ENCRPM, 32'h0);
    run <= 1'b0;
    wt(W);
    rd(`EFS_REG_ENCRPM, 32'h0);
    rd(`EFS_REG_MOTPCT, 32'h0);
    $display("idle done");
    wt(2);
    end_sim();
  end
endmodule
`default_nettype wire
